/* File: rtl/isr_map.svh */
// Register offsets, field positions, reset values and counts of the deep idle release control
// Function
// - Any unmasked request ends deep idle
// - Wake-mask bits set block their request kind
// - Slow noise filter stops pin three waking
// - Lower-priority wake: exit, no ack, keep pending
// - Higher priority or non-maskable: exit and acknowledge
// - Non-maskable wake branches after setup time
// - Enabled maskable wake: setup, then vector or continue
// - Disabled maskable wake: setup, then next instruction
// - Reset in deep idle acts as normal reset
// - Interrupt controller clock off, detection still live
// - Interval timer runs on osc/8 or subclock
// - Watch timer runs on subclock or divided main
// - Clocked serial runs only on external clock
// - Async serial stops except channel 0 external
// - Converter holds operation and keeps result
// - Ports keep levels and directions
// - Processor state and memory preserved
// - Flash setup interval observed before resuming
// - Main oscillator runs; processor, PLL, flash, peripheral and interrupt controller clocks gated
// - Interrupt wake runs stabilization counter to overflow
`ifndef ISR_MAP_SVH
`define ISR_MAP_SVH
`define ISR_OFF_POWER_SAVE_CONTROL 12'h000
`define ISR_OFF_POWER_MODE_SELECT 12'h004
`define ISR_OFF_NOISE_FILTER_CONTROL 12'h008
`define ISR_OFF_STABILIZATION_TIME 12'h00c
`define ISR_OFF_PERIPH_CLOCK_CFG 12'h010
`define ISR_OFF_STATUS 12'h014
`define ISR_OFF_EXT_IRQ_ENABLE 12'h018
`define ISR_PSC_NMI_MASK_A_BIT 0
`define ISR_PSC_NMI_MASK_B_BIT 1
`define ISR_PSC_INT_MASK_BIT 2
`define ISR_PSC_TRIGGER_BIT 3
`define ISR_MODE_DEEP_IDLE 2'h2
`define ISR_NFC_ENABLE_BIT 3
`define ISR_NFC_SLOW_FIRST 3'h3
`define ISR_STAB_SEL_RESET 3'h3
`define ISR_STAB_BASE_BITS 13
`define ISR_STAB_CNT_W 24
`define ISR_PCFG_SUBCLOCK_USED 0
`define ISR_PCFG_TIMER_OSC8 1
`define ISR_PCFG_TIMER_SUB 2
`define ISR_PCFG_WATCH_BRG 3
`define ISR_PCFG_CSI0_EXT 4
`define ISR_PCFG_CSI1_EXT 5
`define ISR_PCFG_UART0_EXT 6
`define ISR_EXT_IRQ_N 8
`define ISR_EXT_PIN_THREE 3
`endif

/* File: rtl/isr_pkg.sv */
// Types of the deep idle release control
package isr_pkg;
  `include "isr_map.svh"
  typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_SETUP} isr_state_t;
  typedef struct packed {
    isr_state_t state;
    logic mask_a;
    logic mask_b;
    logic int_mask;
    logic [1:0] mode_sel;
    logic nf_en;
    logic [2:0] nf_sel;
    logic [2:0] stab_sel;
    logic [6:0] pcfg;
    logic [`ISR_EXT_IRQ_N-1:0] ext_en;
    logic [`ISR_EXT_IRQ_N-1:0] ext_s1;
    logic [`ISR_EXT_IRQ_N-1:0] ext_s2;
    logic nmi_s1;
    logic nmi_s2;
    logic [`ISR_STAB_CNT_W-1:0] cnt;
    logic woke_nmi;
    logic woke_ack;
    logic ack;
    logic vector;
    logic next_instr;
    logic keep_pending;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic intc_clk_en;
    logic pll_clk_en;
    logic flash_clk_en;
    logic timer_clk_en;
    logic watch_clk_en;
    logic csi0_clk_en;
    logic csi1_clk_en;
    logic uart0_clk_en;
    logic uart1_clk_en;
    logic adc_hold;
    logic port_hold;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } isr_regs_t;
endpackage : isr_pkg

/* File: rtl/isr_release_ctrl.sv */
// Deep idle entry, wake detection, setup wait and peripheral clock gating with an APB register file
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "isr_map.svh"
module isr_release_ctrl #(
  parameter int STAB_BASE_BITS = `ISR_STAB_BASE_BITS
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic nmi_pin,
  input wire logic wdt_nmi_req,
  input wire logic [`ISR_EXT_IRQ_N-1:0] ext_irq_pin,
  input wire logic periph_irq_req,
  input wire logic [2:0] req_priority,
  input wire logic [2:0] serv_priority,
  input wire logic in_service,
  input wire logic global_int_en,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic main_osc_en,
  output logic cpu_clk_en,
  output logic pll_clk_en,
  output logic flash_clk_en,
  output logic periph_clk_en,
  output logic intc_clk_en,
  output logic timer_clk_en,
  output logic watch_clk_en,
  output logic csi0_clk_en,
  output logic csi1_clk_en,
  output logic uart0_clk_en,
  output logic uart1_clk_en,
  output logic adc_hold,
  output logic port_hold,
  output logic wake_ack,
  output logic wake_vector,
  output logic wake_next_instr,
  output logic wake_keep_pending
);

  localparam int CNT_W = `ISR_STAB_CNT_W;

  // Largest select must still fit the counter
  if (STAB_BASE_BITS < 1 || STAB_BASE_BITS + 7 >= CNT_W) begin : g_bad_base
    $error("STAB_BASE_BITS out of range for the stabilization counter");
  end

  isr_pkg::isr_regs_t cur_r;
  isr_pkg::isr_regs_t cur_nxt;

  logic [4:0] stab_shift;
  logic [CNT_W-1:0] stab_last;
  logic pin3_blocked;
  logic [`ISR_EXT_IRQ_N-1:0] ext_live;
  logic nmi_a_wake;
  logic nmi_b_wake;
  logic mask_wake;
  logic wake_any;
  logic prio_higher;
  logic wr_en;
  logic rd_en;
  logic entry_req;
  logic [31:0] rd_val;
  logic rd_hit;

  always_comb begin
    stab_shift = 5'(STAB_BASE_BITS) + {2'h0, cur_r.stab_sel};
    stab_last = (CNT_W'(1) << stab_shift) - CNT_W'(1);
    // Slow sampling clocks would miss the pin while the system clock is gated
    pin3_blocked = cur_r.nf_en && (cur_r.nf_sel >= `ISR_NFC_SLOW_FIRST);
    ext_live = cur_r.ext_s2 & cur_r.ext_en;
    if (pin3_blocked) begin
      ext_live[`ISR_EXT_PIN_THREE] = 1'b0;
    end
    nmi_a_wake = cur_r.nmi_s2 && !cur_r.mask_a;
    nmi_b_wake = wdt_nmi_req && !cur_r.mask_b;
    mask_wake = ((|ext_live) || periph_irq_req) && !cur_r.int_mask;
    // Priority level plays no part in whether the mode ends
    wake_any = nmi_a_wake || nmi_b_wake || mask_wake;
    // Lower number means higher priority
    prio_higher = !in_service || (req_priority < serv_priority);
  end

  always_comb begin
    wr_en = psel && penable && pwrite && !cur_r.pready;
    rd_en = psel && penable && !pwrite && !cur_r.pready;
    entry_req = wr_en && (paddr == `ISR_OFF_POWER_SAVE_CONTROL) && pwdata[`ISR_PSC_TRIGGER_BIT]
      && (cur_r.mode_sel == `ISR_MODE_DEEP_IDLE);
    rd_hit = 1'b1;
    rd_val = 32'h0;
    unique case (paddr)
      `ISR_OFF_POWER_SAVE_CONTROL: rd_val = {29'h0, cur_r.int_mask, cur_r.mask_b, cur_r.mask_a};
      `ISR_OFF_POWER_MODE_SELECT: rd_val = {30'h0, cur_r.mode_sel};
      `ISR_OFF_NOISE_FILTER_CONTROL: rd_val = {28'h0, cur_r.nf_en, cur_r.nf_sel};
      `ISR_OFF_STABILIZATION_TIME: rd_val = {29'h0, cur_r.stab_sel};
      `ISR_OFF_PERIPH_CLOCK_CFG: rd_val = {25'h0, cur_r.pcfg};
      `ISR_OFF_STATUS: rd_val = {26'h0, cur_r.woke_ack, cur_r.woke_nmi, cur_r.keep_pending, pin3_blocked,
        cur_r.state};
      `ISR_OFF_EXT_IRQ_ENABLE: rd_val = {24'h0, cur_r.ext_en};
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    cur_nxt = cur_r;
    // Pin requests cross into this clock; the first stage feeds only the second
    cur_nxt.ext_s1 = ext_irq_pin;
    cur_nxt.ext_s2 = cur_r.ext_s1;
    cur_nxt.nmi_s1 = nmi_pin;
    cur_nxt.nmi_s2 = cur_r.nmi_s1;
    cur_nxt.ack = 1'b0;
    cur_nxt.vector = 1'b0;
    cur_nxt.next_instr = 1'b0;
    cur_nxt.pready = 1'b0;
    cur_nxt.pslverr = 1'b0;

    if (psel && penable && !cur_r.pready) begin
      cur_nxt.pready = 1'b1;
      cur_nxt.pslverr = !rd_hit;
    end
    if (rd_en) begin
      cur_nxt.prdata = rd_hit ? rd_val : 32'h0;
    end
    if (wr_en) begin
      unique case (paddr)
        `ISR_OFF_POWER_SAVE_CONTROL: begin
          cur_nxt.mask_a = pwdata[`ISR_PSC_NMI_MASK_A_BIT];
          cur_nxt.mask_b = pwdata[`ISR_PSC_NMI_MASK_B_BIT];
          cur_nxt.int_mask = pwdata[`ISR_PSC_INT_MASK_BIT];
        end
        `ISR_OFF_POWER_MODE_SELECT: cur_nxt.mode_sel = pwdata[1:0];
        `ISR_OFF_NOISE_FILTER_CONTROL: begin
          cur_nxt.nf_en = pwdata[`ISR_NFC_ENABLE_BIT];
          cur_nxt.nf_sel = pwdata[2:0];
        end
        `ISR_OFF_STABILIZATION_TIME: cur_nxt.stab_sel = pwdata[2:0];
        `ISR_OFF_PERIPH_CLOCK_CFG: cur_nxt.pcfg = pwdata[6:0];
        `ISR_OFF_EXT_IRQ_ENABLE: cur_nxt.ext_en = pwdata[`ISR_EXT_IRQ_N-1:0];
        default: ;
      endcase
    end

    unique case (cur_r.state)
      isr_pkg::ST_RUN: begin
        if (entry_req) begin
          // Trigger bit is not stored; it acts only as the entry strobe
          cur_nxt.state = isr_pkg::ST_IDLE;
          cur_nxt.keep_pending = 1'b0;
        end
      end
      isr_pkg::ST_IDLE: begin
        // Sampled every cycle here; a request already pending at entry ends the mode at once
        if (wake_any) begin
          cur_nxt.state = isr_pkg::ST_SETUP;
          cur_nxt.cnt = '0;
          cur_nxt.woke_nmi = nmi_a_wake || nmi_b_wake;
          cur_nxt.woke_ack = nmi_a_wake || nmi_b_wake || (global_int_en && prio_higher);
        end
      end
      isr_pkg::ST_SETUP: begin
        cur_nxt.cnt = cur_r.cnt + CNT_W'(1);
        if (cur_r.cnt == stab_last) begin
          cur_nxt.state = isr_pkg::ST_RUN;
          if (cur_r.woke_nmi) begin
            cur_nxt.ack = 1'b1;
            cur_nxt.vector = 1'b1;
          end else if (cur_r.woke_ack) begin
            cur_nxt.ack = 1'b1;
            cur_nxt.vector = 1'b1;
          end else begin
            cur_nxt.next_instr = 1'b1;
            // Request is marked pending for later service only while interrupts are enabled
            cur_nxt.keep_pending = global_int_en;
          end
        end
      end
      // Spare code of the state field falls back to run
      default: cur_nxt.state = isr_pkg::ST_RUN;
    endcase

    // Gating follows the next state so outputs change with it
    if (cur_nxt.state == isr_pkg::ST_RUN) begin
      cur_nxt.cpu_clk_en = 1'b1;
      cur_nxt.periph_clk_en = 1'b1;
      cur_nxt.intc_clk_en = 1'b1;
      cur_nxt.pll_clk_en = 1'b1;
      cur_nxt.flash_clk_en = 1'b1;
      cur_nxt.timer_clk_en = 1'b1;
      cur_nxt.watch_clk_en = 1'b1;
      cur_nxt.csi0_clk_en = 1'b1;
      cur_nxt.csi1_clk_en = 1'b1;
      cur_nxt.uart0_clk_en = 1'b1;
      cur_nxt.uart1_clk_en = 1'b1;
      cur_nxt.adc_hold = 1'b0;
      cur_nxt.port_hold = 1'b0;
    end else begin
      cur_nxt.cpu_clk_en = 1'b0;
      cur_nxt.periph_clk_en = 1'b0;
      cur_nxt.intc_clk_en = 1'b0;
      // Flash and PLL restart during setup; processor waits for the count
      cur_nxt.pll_clk_en = (cur_nxt.state == isr_pkg::ST_SETUP);
      cur_nxt.flash_clk_en = (cur_nxt.state == isr_pkg::ST_SETUP);
      cur_nxt.timer_clk_en = cur_r.pcfg[`ISR_PCFG_TIMER_OSC8]
        || (cur_r.pcfg[`ISR_PCFG_SUBCLOCK_USED] && cur_r.pcfg[`ISR_PCFG_TIMER_SUB]);
      cur_nxt.watch_clk_en = cur_r.pcfg[`ISR_PCFG_SUBCLOCK_USED] || cur_r.pcfg[`ISR_PCFG_WATCH_BRG];
      cur_nxt.csi0_clk_en = cur_r.pcfg[`ISR_PCFG_CSI0_EXT];
      cur_nxt.csi1_clk_en = cur_r.pcfg[`ISR_PCFG_CSI1_EXT];
      cur_nxt.uart0_clk_en = cur_r.pcfg[`ISR_PCFG_UART0_EXT];
      cur_nxt.uart1_clk_en = 1'b0;
      cur_nxt.adc_hold = 1'b1;
      cur_nxt.port_hold = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Reset in any state returns to run exactly as at power-up
      cur_r <= '0;
      cur_r.state <= isr_pkg::ST_RUN;
      cur_r.stab_sel <= `ISR_STAB_SEL_RESET;
      cur_r.cpu_clk_en <= 1'b1;
      cur_r.periph_clk_en <= 1'b1;
      cur_r.intc_clk_en <= 1'b1;
      cur_r.pll_clk_en <= 1'b1;
      cur_r.flash_clk_en <= 1'b1;
      cur_r.timer_clk_en <= 1'b1;
      cur_r.watch_clk_en <= 1'b1;
      cur_r.csi0_clk_en <= 1'b1;
      cur_r.csi1_clk_en <= 1'b1;
      cur_r.uart0_clk_en <= 1'b1;
      cur_r.uart1_clk_en <= 1'b1;
    end else if (clk_en) begin
      cur_r <= cur_nxt;
    end
  end

  // Oscillator is never gated by this block
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_osc_en <= 1'b1;
    end else begin
      main_osc_en <= 1'b1;
    end
  end

  always_comb begin
    prdata = cur_r.prdata;
    pready = cur_r.pready;
    pslverr = cur_r.pslverr;
    cpu_clk_en = cur_r.cpu_clk_en;
    pll_clk_en = cur_r.pll_clk_en;
    flash_clk_en = cur_r.flash_clk_en;
    periph_clk_en = cur_r.periph_clk_en;
    intc_clk_en = cur_r.intc_clk_en;
    timer_clk_en = cur_r.timer_clk_en;
    watch_clk_en = cur_r.watch_clk_en;
    csi0_clk_en = cur_r.csi0_clk_en;
    csi1_clk_en = cur_r.csi1_clk_en;
    uart0_clk_en = cur_r.uart0_clk_en;
    uart1_clk_en = cur_r.uart1_clk_en;
    adc_hold = cur_r.adc_hold;
    port_hold = cur_r.port_hold;
    wake_ack = cur_r.ack;
    wake_vector = cur_r.vector;
    wake_next_instr = cur_r.next_instr;
    wake_keep_pending = cur_r.keep_pending;
  end

endmodule : isr_release_ctrl

/* File: tb/isr_release_chk.sv */
// Port-level assertions for the deep idle release control
`timescale 1ns/10ps
module isr_release_chk (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic main_osc_en,
  input wire logic cpu_clk_en,
  input wire logic pll_clk_en,
  input wire logic intc_clk_en,
  input wire logic uart1_clk_en,
  input wire logic adc_hold,
  input wire logic port_hold,
  input wire logic wake_ack,
  input wire logic wake_vector,
  input wire logic wake_next_instr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  AST_OSC: assert property (main_osc_en) else $error("oscillator off");
  AST_GATE: assert property ($fell(cpu_clk_en) |-> !pll_clk_en && !intc_clk_en && adc_hold)
    else $error("idle gating wrong");
  AST_HOLD: assert property (adc_hold == port_hold && port_hold == !cpu_clk_en)
    else $error("hold levels wrong");
  AST_UART1: assert property (port_hold |-> !uart1_clk_en) else $error("uart1 runs");
  AST_RESUME: assert property ($rose(cpu_clk_en) |-> wake_ack ^ wake_next_instr)
    else $error("resume without one outcome");
  AST_PULSE: assert property (wake_ack || wake_next_instr |-> $rose(cpu_clk_en) ##1 !(wake_ack || wake_next_instr))
    else $error("outcome pulse misplaced");
  AST_VEC: assert property (wake_vector == wake_ack) else $error("vector without ack");
  AST_SETUP: assert property ($rose(pll_clk_en) |-> !cpu_clk_en [*2]) else $error("setup too short");
  AST_APB: assert property (psel && penable && !pready && clk_en |=> pready) else $error("no apb answer");
endmodule : isr_release_chk

bind isr_release_ctrl isr_release_chk chk_u (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pready(pready), .main_osc_en(main_osc_en), .cpu_clk_en(cpu_clk_en),
  .pll_clk_en(pll_clk_en), .intc_clk_en(intc_clk_en), .uart1_clk_en(uart1_clk_en), .adc_hold(adc_hold),
  .port_hold(port_hold), .wake_ack(wake_ack), .wake_vector(wake_vector), .wake_next_instr(wake_next_instr));

/* File: tb/isr_wake_model.sv */
// Wake sources and interrupt controller stand-in
`timescale 1ns/10ps
module isr_wake_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic req_go,
  input wire logic [10:0] req_sel,
  input wire logic wake_ack,
  input wire logic wake_next_instr,
  output logic nmi_pin,
  output logic wdt_nmi_req,
  output logic periph_irq_req,
  output logic [7:0] ext_irq_pin
);
  logic [10:0] pend_r;
  // Levels held until the core resumes, so a masked request is still there later
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) pend_r <= 11'h000;
    else if (wake_ack || wake_next_instr) pend_r <= 11'h000;
    else if (req_go) pend_r <= pend_r | req_sel;
  end
  assign {ext_irq_pin, periph_irq_req, wdt_nmi_req, nmi_pin} = pend_r;
endmodule : isr_wake_model

/* File: tb/tb_top.sv */
// Self-checking bench for the deep idle release control
`timescale 1ns/10ps
module tb_top;
  localparam int SETUP = 16;
  logic sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, req_go = 1'b0;
  logic in_service = 1'b0, global_int_en = 1'b0, clk_en = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] req_priority = 3'h0, serv_priority = 3'h0;
  logic [10:0] req_sel = 11'h000;
  logic [7:0] ext_irq_pin;
  logic nmi_pin, wdt_nmi_req, periph_irq_req, pready, pslverr, err;
  logic main_osc_en, cpu_clk_en, pll_clk_en, flash_clk_en, periph_clk_en, intc_clk_en, timer_clk_en;
  logic watch_clk_en, csi0_clk_en, csi1_clk_en, uart0_clk_en, uart1_clk_en, adc_hold, port_hold;
  logic wake_ack, wake_vector, wake_next_instr, wake_keep_pending;
  int n_fail = 0;
  int tests_run = 0;
  always #50 sys_clk = ~sys_clk;
  // Short setup base keeps each wake near SETUP cycles
  isr_release_ctrl #(.STAB_BASE_BITS(1)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .nmi_pin(nmi_pin),
    .wdt_nmi_req(wdt_nmi_req), .ext_irq_pin(ext_irq_pin), .periph_irq_req(periph_irq_req),
    .req_priority(req_priority), .serv_priority(serv_priority), .in_service(in_service),
    .global_int_en(global_int_en), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_osc_en(main_osc_en), .cpu_clk_en(cpu_clk_en), .pll_clk_en(pll_clk_en), .flash_clk_en(flash_clk_en),
    .periph_clk_en(periph_clk_en), .intc_clk_en(intc_clk_en), .timer_clk_en(timer_clk_en),
    .watch_clk_en(watch_clk_en), .csi0_clk_en(csi0_clk_en), .csi1_clk_en(csi1_clk_en),
    .uart0_clk_en(uart0_clk_en), .uart1_clk_en(uart1_clk_en), .adc_hold(adc_hold), .port_hold(port_hold),
    .wake_ack(wake_ack), .wake_vector(wake_vector), .wake_next_instr(wake_next_instr),
    .wake_keep_pending(wake_keep_pending));
  isr_wake_model src_u (.sys_clk(sys_clk), .reset_n(reset_n), .req_go(req_go), .req_sel(req_sel),
    .wake_ack(wake_ack), .wake_next_instr(wake_next_instr), .nmi_pin(nmi_pin), .wdt_nmi_req(wdt_nmi_req),
    .periph_irq_req(periph_irq_req), .ext_irq_pin(ext_irq_pin));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    while (pready !== 1'b1 && t < 40) begin
      @(posedge sys_clk);
      t++;
    end
    if (pready !== 1'b1) begin
      n_fail++;
      $display("unexpected pready exp 1 got %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never drives psel twice in one step
    @(posedge sys_clk);
  endtask : apb
  task automatic enter(input logic [2:0] m);
    // Bench never starts a conversion, so entry always finds the converter stopped
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b1, 12'h000, {28'h0, 1'b1, m});
    chk("port_hold", 1'b1, port_hold);
  endtask : enter
  task automatic fire(input logic [10:0] s);
    req_sel <= s;
    req_go <= 1'b1;
    @(posedge sys_clk);
    req_go <= 1'b0;
  endtask : fire
  task automatic resume(input logic a, input logic k, input logic tl);
    int n;
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    if (tl) chk("setup", 1'b1, n >= SETUP && n <= SETUP + 6);
    chk("wake_ack", a, wake_ack);
    chk("wake_vector", a, wake_vector);
    chk("wake_next_instr", !a, wake_next_instr);
    chk("keep_pending", k, wake_keep_pending);
  endtask : resume
  task automatic s_reset;
    chk("clocks", 4'hf, {main_osc_en, cpu_clk_en, pll_clk_en, intc_clk_en});
    apb(1'b0, 12'h00c, 32'h0);
    chk("stab_sel", 32'h3, rd);
    apb(1'b1, 12'h000, 32'h8);
    chk("no entry", 1'b0, port_hold);
    apb(1'b0, 12'h01c, 32'h0);
    chk("unmapped", 32'h8000_0000, {err, rd[30:0]});
  endtask : s_reset
  task automatic s_gate;
    logic [6:0] c;
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'h05;
      apb(1'b1, 12'h010, {25'h0, c});
      enter(3'h0);
      chk("timer_clk_en", c[1] | (c[0] & c[2]), timer_clk_en);
      chk("watch_clk_en", c[0] | c[3], watch_clk_en);
      chk("csi_clk_en", c[5:4], {csi1_clk_en, csi0_clk_en});
      chk("uart_clk_en", c[6], {uart1_clk_en, uart0_clk_en});
      chk("gated", 3'h0, {pll_clk_en, flash_clk_en, periph_clk_en});
      apb(1'b0, 12'h014, 32'h0);
      chk("state", 2'h1, rd[1:0]);
      fire(11'h002);
      resume(1'b1, 1'b0, 1'b1);
    end
  endtask : s_gate
  task automatic s_mask;
    for (int i = 0; i < 3; i++) begin
      enter(3'h1 << i);
      fire(11'h001 << i);
      repeat (8) @(posedge sys_clk);
      chk("masked", 1'b0, pll_clk_en);
      apb(1'b1, 12'h000, 32'h0);
      resume(i < 2, 1'b0, 1'b0);
    end
  endtask : s_mask
  task automatic s_prio;
    global_int_en <= 1'b1;
    in_service <= 1'b1;
    serv_priority <= 3'h2;
    for (int i = 0; i < 3; i++) begin
      req_priority <= (i == 1) ? 3'h1 : 3'h5;
      enter(3'h0);
      fire((i == 2) ? 11'h001 : 11'h004);
      resume(i > 0, i == 0, 1'b0);
    end
    global_int_en <= 1'b0;
    in_service <= 1'b0;
  endtask : s_prio
  task automatic s_pin3;
    apb(1'b1, 12'h018, 32'h0c);
    apb(1'b1, 12'h008, 32'h0b);
    enter(3'h0);
    fire(11'h040);
    repeat (8) @(posedge sys_clk);
    chk("pin3", 1'b0, pll_clk_en);
    fire(11'h020);
    resume(1'b0, 1'b0, 1'b1);
  endtask : s_pin3
  task automatic s_rst_idle;
    enter(3'h0);
    clk_en <= 1'b0;
    fire(11'h002);
    repeat (3) @(posedge sys_clk);
    // Frozen flops must stay in idle although a wake is pending
    chk("frozen", 1'b0, pll_clk_en);
    reset_n <= 1'b0;
    clk_en <= 1'b1;
    @(posedge sys_clk);
    chk("reset cpu", 2'h2, {cpu_clk_en, adc_hold});
    reset_n <= 1'b1;
    @(posedge sys_clk);
    apb(1'b0, 12'h00c, 32'h0);
    chk("reset stab", 32'h3, rd);
  endtask : s_rst_idle
  task automatic finish_test;
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    finish_test;
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    s_reset;
    s_gate;
    s_mask;
    s_prio;
    s_pin3;
    s_rst_idle;
    finish_test;
  end
endmodule : tb_top
